// *** rtl/pcc_ctrl.sv ***
// Control-signal logic of one 16-bit card socket: battery decode, speaker
// combine, DMA requests, card detect, byte enables and I/O strobes.
// Assumes host cycle requests arrive synchronous to clk; card pins do not.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Both detect high good; second low weak; first low dead, data lost.
// - Speaker bit only valid in I/O mode; otherwise a battery detect.
// - Speaker bits of all sockets are combined onto one audio output.
// - Second battery line is accepted as DMA request during DMA to card.
// - First enable selects even bytes, second enable selects odd bytes.
// - Input acknowledge may strobe a DMA request during DMA from card.
// - I/O read strobe asserted during host I/O reads.
// - I/O read strobe is the DMA write strobe, card to memory.
// - I/O write strobe driven low during host I/O writes.
// - I/O write strobe is the DMA strobe, memory to card.
// - First battery line is status change in I/O mode, raised upward.
module pcc_ctrl
#(
    parameter int SOCKETS = 2
)
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               io_mode,
    input  wire logic               dma_src_sel,
    input  wire logic [2:0]         cyc_kind,
    input  wire logic [1:0]         byte_sel,
    input  wire logic               batt1_pin,
    input  wire logic               batt2_pin,
    input  wire logic               detect1_pin,
    input  wire logic               detect2_pin,
    input  wire logic               in_ack_n_pin,
    input  wire logic [SOCKETS-2:0] other_spkr,
    output logic                    card_en1_n,
    output logic                    card_en2_n,
    output logic                    io_rd_n,
    output logic                    io_wr_n,
    output logic [1:0]              batt_state,
    output logic                    card_present,
    output logic                    status_change,
    output logic                    ring_ind,
    output logic                    spkr_bit,
    output logic                    combined_audio_out,
    output logic                    dma_req,
    output logic                    io_rd_ack
);

    logic [4:0]              pins_s;
    logic                    b1;
    logic                    b2;
    logic                    cd1;
    logic                    cd2;
    logic                    ack_n;
    logic                    dma_in;
    logic                    dma_out;
    pcc_pkg::pcc_cyc_e       cyc;
    logic                    nxt_ack_n_d;
    logic                    ack_n_d_ff;

    pcc_sync #(.WIDTH(5)) u_sync
    (
        .clk      (clk),
        .rst      (rst),
        .async_in ({batt1_pin, batt2_pin, detect1_pin, detect2_pin,
                    in_ack_n_pin}),
        .sync_out (pins_s)
    );

    assign b1    = pins_s[4];
    assign b2    = pins_s[3];
    assign cd1   = pins_s[2];
    assign cd2   = pins_s[1];
    assign ack_n = pins_s[0];
    assign cyc   = pcc_pkg::pcc_cyc_e'(cyc_kind);
    assign dma_out = (cyc == pcc_pkg::PCC_CYC_DMA_TO_CARD);
    assign dma_in  = (cyc == pcc_pkg::PCC_CYC_DMA_FROM_CARD);
    assign nxt_ack_n_d = ack_n;

    // Battery condition of a memory card; meaningless in I/O mode.
    function automatic logic [1:0] batt_decode(input logic v1, input logic v2);
        if (!v1)
            batt_decode = pcc_pkg::PCC_BATT_DEAD;
        else if (!v2)
            batt_decode = pcc_pkg::PCC_BATT_WEAK;
        else
            batt_decode = pcc_pkg::PCC_BATT_GOOD;
    endfunction

    // Edge memory of the acknowledge line, for strobe-style DMA requests.
    always_ff @(posedge clk)
    begin
        if (rst)
            ack_n_d_ff <= pcc_pkg::PIN_IDLE;
        else
            ack_n_d_ff <= nxt_ack_n_d;
    end

    // Status outputs are registered so they come from flip-flops.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            batt_state    <= pcc_pkg::PCC_BATT_GOOD;
            card_present  <= pcc_pkg::SOCKET_CNT;
            status_change <= 1'h0;
            ring_ind      <= 1'h0;
            spkr_bit      <= 1'h0;
            io_rd_ack     <= 1'h0;
        end
        else
        begin
            batt_state    <= io_mode ? pcc_pkg::PCC_BATT_GOOD
                                     : batt_decode(b1, b2);
            card_present  <= !cd1 && !cd2;
            status_change <= io_mode && !b1;
            ring_ind      <= io_mode && !b1;
            spkr_bit      <= io_mode && b2 && !dma_out;
            io_rd_ack     <= !ack_n && (cyc == pcc_pkg::PCC_CYC_IO_RD);
        end
    end

    // Audio is a binary level, so exclusive-or keeps both tones audible.
    always_ff @(posedge clk)
    begin
        if (rst)
            combined_audio_out <= 1'h0;
        else
            combined_audio_out <= (io_mode && b2 && !dma_out) ^ (^other_spkr);
    end

    // DMA request, chosen by source select.
    always_ff @(posedge clk)
    begin
        if (rst)
            dma_req <= 1'h0;
        else if (dma_src_sel == pcc_pkg::DMA_SRC_BATT2)
            dma_req <= dma_out && b2;
        else
            dma_req <= dma_in && ack_n_d_ff && !ack_n;
    end

    // Strobes and enables are registered active-low outputs.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            card_en1_n <= pcc_pkg::STROBE_IDLE_N;
            card_en2_n <= pcc_pkg::STROBE_IDLE_N;
            io_rd_n    <= pcc_pkg::STROBE_IDLE_N;
            io_wr_n    <= pcc_pkg::STROBE_IDLE_N;
        end
        else
        begin
            card_en1_n <= !(cyc != pcc_pkg::PCC_CYC_NONE && byte_sel[0]);
            card_en2_n <= !(cyc != pcc_pkg::PCC_CYC_NONE && byte_sel[1]);
            io_rd_n    <= !(cyc == pcc_pkg::PCC_CYC_IO_RD || dma_in);
            io_wr_n    <= !(cyc == pcc_pkg::PCC_CYC_IO_WR || dma_out);
        end
    end

    // All checks below live in the one clock domain of this block.
    default clocking cb_main @(posedge clk);
    endclocking
    default disable iff (rst);

    // A pin level needs four sampling edges to reach a registered output.
    sequence s_card_seated;
        (!detect1_pin && !detect2_pin) [*4];
    endsequence
    sequence s_dead_batt;
        (!io_mode && !batt1_pin) [*4];
    endsequence
    sequence s_io_b1_low;
        (io_mode && !batt1_pin) [*4];
    endsequence
    sequence s_batt2_dma;
        (dma_src_sel == pcc_pkg::DMA_SRC_BATT2 && dma_out && batt2_pin) [*4];
    endsequence
    // The acknowledge pin must be seen idle twice so the edge is real.
    sequence s_ack_fall;
        in_ack_n_pin [*2] ##1 !in_ack_n_pin;
    endsequence

    a_read_strobe: assert property
        ((cyc == pcc_pkg::PCC_CYC_IO_RD) |=> !io_rd_n)
        else $error("read strobe missing");
    a_dma_rd_strobe: assert property
        (dma_in |=> !io_rd_n && io_wr_n)
        else $error("dma read strobe wrong");
    a_write_strobe: assert property
        ((cyc == pcc_pkg::PCC_CYC_IO_WR) |=> !io_wr_n && io_rd_n)
        else $error("write strobe wrong");
    a_dma_wr_strobe: assert property
        (dma_out |=> !io_wr_n)
        else $error("dma write strobe missing");
    a_byte_enable: assert property
        ((cyc != pcc_pkg::PCC_CYC_NONE) |=>
            (card_en1_n == !$past(byte_sel[0])) &&
            (card_en2_n == !$past(byte_sel[1])))
        else $error("byte enable mismatch");
    a_card_detect: assert property
        (s_card_seated |-> card_present)
        else $error("card not reported");
    a_batt_dead: assert property
        (s_dead_batt |-> batt_state == pcc_pkg::PCC_BATT_DEAD)
        else $error("dead battery missed");
    a_spkr_gate: assert property
        (!$past(io_mode) |-> !spkr_bit)
        else $error("speaker outside io mode");
    a_dma_batt: assert property
        (dma_req |-> $past(dma_out || dma_in))
        else $error("dma request outside dma");
    a_dma_batt_req: assert property
        (s_batt2_dma |-> dma_req)
        else $error("battery dma request missed");
    a_dma_ack_req: assert property
        (s_ack_fall ##2 (dma_src_sel == pcc_pkg::DMA_SRC_ACK && dma_in)
            |=> dma_req)
        else $error("acknowledge dma request missed");
    a_stat_change: assert property
        (s_io_b1_low |-> status_change)
        else $error("status change missed");

endmodule
`default_nettype wire

// *** rtl/pcc_pkg.sv ***
// Package for the 16-bit card socket control-signal block.
// Assumes a single 10 MHz clock and synchronous active-high reset.
package pcc_pkg;

    // Battery condition codes decoded from the two detect lines.
    typedef enum logic [1:0]
    {
        PCC_BATT_GOOD,
        PCC_BATT_WEAK,
        PCC_BATT_DEAD
    } pcc_batt_e;

    // Socket cycle kinds requested by the host side.
    typedef enum logic [2:0]
    {
        PCC_CYC_NONE,
        PCC_CYC_IO_RD,
        PCC_CYC_IO_WR,
        PCC_CYC_MEM,
        PCC_CYC_DMA_FROM_CARD,
        PCC_CYC_DMA_TO_CARD
    } pcc_cyc_e;

    // Request source selection for DMA.
    localparam logic DMA_SRC_BATT2 = 1'h0;
    localparam logic DMA_SRC_ACK   = 1'h1;

    // Synchroniser depth and reset values.
    localparam int   SYNC_STAGES   = 2;
    localparam logic PIN_IDLE      = 1'h1;
    localparam logic STROBE_IDLE_N = 1'h1;
    localparam logic SOCKET_CNT    = 1'h0;

endpackage

// *** rtl/pcc_sync.sv ***
// Two flip-flop synchroniser for a bundle of card input pins.
// Assumes pins change asynchronously to clk; the first stage is read
// only by the second.
`timescale 1ns/100ps
`default_nettype none
module pcc_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_ff  <= {WIDTH{pcc_pkg::PIN_IDLE}};
            sync_out <= {WIDTH{pcc_pkg::PIN_IDLE}};
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule
`default_nettype wire

// *** verification/pc_card_16bit_control_signals_bench.sv ***
// Self-checking bench for the socket control-signal block.
// Assumes the card model drives all card pins, inputs change at negedge.
`timescale 1ns/100ps
`default_nettype none
module pc_card_16bit_control_signals_bench;
    logic       clk, rst, io_mode, dma_src_sel, ins, g1, g2, can_ack;
    logic       ack_stb, b1p, b2p, d1p, d2p, ackp, en1_n, en2_n, rd_n;
    logic       wr_n, pres, stc, ring, spk, aud, dreq, rdack;
    logic [2:0] cyc_kind;
    logic [1:0] byte_sel, batt;
    logic [0:0] other_spkr;
    int         mismatches, total_checks, cycles, n;

    pcc_ctrl #(.SOCKETS(2)) i_pcc_ctrl (.clk(clk), .rst(rst),
        .io_mode(io_mode), .dma_src_sel(dma_src_sel), .cyc_kind(cyc_kind),
        .byte_sel(byte_sel), .batt1_pin(b1p), .batt2_pin(b2p),
        .detect1_pin(d1p), .detect2_pin(d2p), .in_ack_n_pin(ackp),
        .other_spkr(other_spkr), .card_en1_n(en1_n), .card_en2_n(en2_n),
        .io_rd_n(rd_n), .io_wr_n(wr_n), .batt_state(batt),
        .card_present(pres), .status_change(stc), .ring_ind(ring),
        .spkr_bit(spk), .combined_audio_out(aud), .dma_req(dreq),
        .io_rd_ack(rdack));
    pcc_card_model i_pcc_card_model (.inserted(ins), .batt1_good(g1),
        .batt2_good(g2), .can_ack(can_ack), .ack_strobe(ack_stb),
        .io_rd_n(rd_n), .batt1_pin(b1p), .batt2_pin(b2p),
        .detect1_pin(d1p), .detect2_pin(d2p), .in_ack_n_pin(ackp));

    task automatic end_of_test();
        $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input int exp);
        total_checks++;
        if (got !== 4'(exp))
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, 4'(exp));
        end
    endtask

    task automatic check_strobes();
        int c;
        c = int'(cyc_kind);
        chk({3'h0, rd_n}, !(c == 1 || c == 4));
        chk({3'h0, wr_n}, !(c == 2 || c == 5));
        chk({3'h0, en1_n}, !(c != 0 && byte_sel[0]));
        chk({3'h0, en2_n}, !(c != 0 && byte_sel[1]));
    endtask

    // Expected values come from the host inputs and the card's commanded pin levels.
    task automatic check_all();
        int c, b1, b2, sp, akn;
        c = int'(cyc_kind);
        b1 = ins ? g1 : 1;
        b2 = ins ? g2 : 1;
        sp = io_mode && b2 && c != 5;
        akn = !(ins && ((can_ack && (c == 1 || c == 4)) || ack_stb));
        chk(batt, io_mode ? 0 : (!b1 ? 2 : (!b2 ? 1 : 0)));
        chk(pres, ins);
        chk(stc, io_mode && !b1);
        chk(ring, io_mode && !b1);
        chk(spk, sp);
        chk(aud, sp ^ other_spkr[0]);
        chk(dreq, !dma_src_sel && c == 5 && b2);
        chk(rdack, c == 1 && !akn);
        check_strobes();
    endtask

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // Ceiling sits well above the roughly 2100 cycles of the sequence.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    initial
    begin
        {rst, ins, g1, g2} = 4'hF;
        {io_mode, dma_src_sel, can_ack, ack_stb, other_spkr} = 5'h00;
        cyc_kind = 3'h0;
        byte_sel = 2'h0;
        void'($urandom(36435));
        repeat (5) @(negedge clk);
        chk({rd_n, wr_n, en1_n, en2_n}, 15);
        rst = 1'h0;
        for (int i = 0; i < 300; i++)
        begin
            @(negedge clk);
            {io_mode, dma_src_sel, other_spkr, ins} = 4'($urandom);
            {g1, g2, can_ack} = 3'($urandom);
            cyc_kind = 3'($urandom_range(5));
            byte_sel = 2'($urandom);
            @(negedge clk);
            check_strobes();
            repeat (5) @(negedge clk);
            check_all();
        end
        // Back-to-back cycle kinds, one clock each, show the strobe latency.
        for (int c = 0; c < 6; c++)
        begin
            cyc_kind = 3'(c);
            @(negedge clk);
            check_strobes();
        end
        {dma_src_sel, io_mode, ins, can_ack} = 4'hE;
        cyc_kind = 3'h4;
        repeat (5) @(negedge clk);
        ack_stb = 1'h1;
        n = 0;
        repeat (6)
        begin
            @(negedge clk);
            n += int'(dreq === 1'h1);
        end
        chk(4'(n), 1);
        end_of_test();
    end
endmodule
`default_nettype wire

// *** verification/pcc_card_model.sv ***
// Behavioural model of an inserted 16-bit card at the socket pins.
// Assumes the bench commands insertion, battery, ack and strobe state.
`timescale 1ns/100ps
`default_nettype none
module pcc_card_model
(
    input  wire logic inserted,
    input  wire logic batt1_good,
    input  wire logic batt2_good,
    input  wire logic can_ack,
    input  wire logic ack_strobe,
    input  wire logic io_rd_n,
    output logic      batt1_pin,
    output logic      batt2_pin,
    output logic      detect1_pin,
    output logic      detect2_pin,
    output logic      in_ack_n_pin
);
    // detect lines grounded
    // An empty slot leaves every line to the socket pull-ups.
    assign #7 detect1_pin = ~inserted;
    assign #7 detect2_pin = ~inserted;
    assign #7 batt1_pin = inserted ? batt1_good : 1'h1;
    assign #7 batt2_pin = inserted ? batt2_good : 1'h1;
    assign #7 in_ack_n_pin = ~(inserted & ((can_ack & ~io_rd_n) | ack_strobe));
endmodule
`default_nettype wire
